// ==== common/tzc_consts.svh ====
// Register indices, field positions, reset values and bus constants of the capture channel.
`ifndef TZC_CONSTS_SVH
`define TZC_CONSTS_SVH

// Register indices; the byte address of each register is four times its index.
`define TZC_IDX_CLK_CTRL   16'hF700
`define TZC_IDX_IO_CTRL    16'hF701
`define TZC_IDX_STATUS     16'hF703
`define TZC_IDX_COUNTER    16'hF706
`define TZC_IDX_CAPTURE    16'hF708
`define TZC_IDX_RUN_CTRL   16'hF720
`define TZC_IDX_SYNC_MODE  16'hF721
`define TZC_IDX_FUNC_MODE  16'hF723
`define TZC_IDX_IRQ_STAT   16'hF730
`define TZC_IDX_IRQ_EN     16'hF731
`define TZC_IDX_IRQ_CLR    16'hF732

// Address decode: index sits in paddr[17:2], bits above must be zero.
`define TZC_IDX_LSB        2
`define TZC_IDX_MSB        17

// Field positions.
`define TZC_FLAG_BIT       0
`define TZC_RUN0_BIT       0
`define TZC_RUN1_BIT       1
`define TZC_SYNC_BIT       0
`define TZC_IRQ_CAP_BIT    0
`define TZC_IRQ_OVF_BIT    1

// Prescaler select code that picks the external clock pin (upper code half).
`define TZC_PSC_EXT_BIT    2
// Capture mode needs I/O control bit 2 set; bits 1:0 then pick the edge.
`define TZC_IO_CAP_BIT     2
`define TZC_EDGE_RISE      2'h0
`define TZC_EDGE_FALL      2'h1

// Widths and reset values.
`define TZC_PRE_W          13
`define TZC_CNT_W          16
`define TZC_REG8_RST       8'h00
`define TZC_REG16_RST      16'h0000
`define TZC_IRQ_W          2

`endif

// ==== common/tzc_pkg.sv ====
// Types shared by the capture channel design files.
package tzc_pkg;

	// Clock control register layout.
	typedef struct packed {
		logic [2:0] unused;
		logic [1:0] edge_sel;
		logic [2:0] psc_sel;
	} tzc_clk_ctrl_t;

	// Register bus answer phase.
	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} tzc_bus_state_t;

	// Synchronised pin levels.
	typedef struct packed {
		logic ext_clk;
		logic cap_pin;
	} tzc_pins_t;

endpackage

// ==== rtl/tzc_sync.sv ====
// Two flip-flop synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
module tzc_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// The first stage feeds only the second one; nothing else may look at it.
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule

// ==== rtl/tzc_capture_top.sv ====
// Single timer channel in input capture mode, with an APB register slave.
// Notes on behaviour
// - A 13-bit prescaler counts up on every system clock cycle.
// - The channel counter is 16 bits, counts up, and software reads and writes it.
// - The counter advances on a prescaled internal clock or the external clock pin.
// - Edge select bits 4:3 at zero make the counter count on rising edges.
// - Prescaler select 3'b011 gives the system clock divided by eight.
// - I/O control 3'b100 makes capture_value capture on capture pin rising edges.
// - Each capture pin edge selected in capture mode copies the present counter value into capture_value.
// - capture_value is 16 bits wide, readable and writable by software.
// - Every capture sets the capture flag, status bit 0.
// - A zero flag means no capture happened since it was last cleared.
// - Run control bit 0 stops (zero, unless sync mode and run bit 1 are set) or starts (one) the channel counter.
// - Sync mode bit 0 selects independent or synchronous counting with channel one.
// - Combination mode bits 1:0 at zero give normal operation of both channels.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "tzc_consts.svh"
module tzc_capture_top (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_input_pin,
	input  wire logic        ext_clock_pin,
	output logic             irq
);

	tzc_pkg::tzc_pins_t                   pins;
	tzc_pkg::tzc_bus_state_t              bus_reg;
	tzc_pkg::tzc_bus_state_t              bus_next;
	tzc_pkg::tzc_clk_ctrl_t               clk_ctrl_reg;
	tzc_pkg::tzc_clk_ctrl_t               clk_ctrl_next;
	logic [`TZC_PRE_W-1:0]                system_prescaler_reg;
	logic [`TZC_PRE_W-1:0]                system_prescaler_next;
	logic [7:0]                           io_ctrl_reg;
	logic [7:0]                           io_ctrl_next;
	logic [7:0]                           run_ctrl_reg;
	logic [7:0]                           run_ctrl_next;
	logic [7:0]                           sync_mode_reg;
	logic [7:0]                           sync_mode_next;
	logic [7:0]                           func_mode_reg;
	logic [7:0]                           func_mode_next;
	logic [`TZC_CNT_W-1:0]                counter_reg;
	logic [`TZC_CNT_W-1:0]                counter_next;
	logic [`TZC_CNT_W-1:0]                capture_reg;
	logic [`TZC_CNT_W-1:0]                capture_next;
	logic                                 flag_reg;
	logic                                 flag_next;
	logic                                 armed_reg;
	logic                                 armed_next;
	logic [`TZC_IRQ_W-1:0]                ist_reg;
	logic [`TZC_IRQ_W-1:0]                ist_next;
	logic [`TZC_IRQ_W-1:0]                ien_reg;
	logic [`TZC_IRQ_W-1:0]                ien_next;
	logic                                 irq_reg;
	logic                                 clk_lvl_prev_reg;
	logic                                 cap_prev_reg;
	logic [31:0]                          prdata_reg;
	logic [31:0]                          prdata_next;
	logic                                 pslverr_reg;
	logic                                 pslverr_next;
	logic [15:0]                          idx;
	logic                                 addr_ok;
	logic                                 mapped;
	logic                                 wr_en;
	logic                                 rd_done;
	logic                                 clk_lvl;
	logic                                 clk_rise;
	logic                                 clk_fall;
	logic                                 tick;
	logic                                 run;
	logic                                 cap_rise;
	logic                                 cap_fall;
	logic                                 cap_event;
	logic                                 ovf_event;
	logic                                 flag_clr;

	// Pins come from outside the clock domain, so both pass two flip-flops first.
	tzc_sync #(
		.WIDTH (2)
	) u_sync (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.async_in ({ext_clock_pin, capture_input_pin}),
		.sync_out (pins)
	);

	// Address decode; the index sits in the word address and upper bits must be clear.
	assign idx     = paddr[`TZC_IDX_MSB:`TZC_IDX_LSB];
	assign addr_ok = (paddr[31:`TZC_IDX_MSB+1] == '0);
	always_comb
	begin
		case (idx)
			`TZC_IDX_CLK_CTRL, `TZC_IDX_IO_CTRL, `TZC_IDX_STATUS, `TZC_IDX_COUNTER,
			`TZC_IDX_CAPTURE, `TZC_IDX_RUN_CTRL, `TZC_IDX_SYNC_MODE, `TZC_IDX_FUNC_MODE,
			`TZC_IDX_IRQ_STAT, `TZC_IDX_IRQ_EN, `TZC_IDX_IRQ_CLR: mapped = addr_ok;
			default: mapped = 1'b0;
		endcase
	end

	// A transfer completes in the access cycle that sees the registered pready high.
	assign wr_en   = psel && penable && (bus_reg == tzc_pkg::BUS_ANSWER) && pwrite && mapped;
	assign rd_done = psel && penable && (bus_reg == tzc_pkg::BUS_ANSWER) && !pwrite && mapped;

	// Bus phase: the setup cycle arms a one-cycle answer, so every access has no wait.
	always_comb
	begin
		bus_next     = tzc_pkg::BUS_IDLE;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		case (bus_reg)
			tzc_pkg::BUS_IDLE:
			begin
				if (psel && !penable)
				begin
					bus_next     = tzc_pkg::BUS_ANSWER;
					pslverr_next = !mapped;
					prdata_next  = 32'h0000_0000;
					case (idx)
						`TZC_IDX_CLK_CTRL:  prdata_next[7:0] = clk_ctrl_reg;
						`TZC_IDX_IO_CTRL:   prdata_next[7:0] = io_ctrl_reg;
						`TZC_IDX_STATUS:    prdata_next[`TZC_FLAG_BIT] = flag_reg;
						`TZC_IDX_COUNTER:   prdata_next[15:0] = counter_reg;
						`TZC_IDX_CAPTURE:   prdata_next[15:0] = capture_reg;
						`TZC_IDX_RUN_CTRL:  prdata_next[7:0] = run_ctrl_reg;
						`TZC_IDX_SYNC_MODE: prdata_next[7:0] = sync_mode_reg;
						`TZC_IDX_FUNC_MODE: prdata_next[7:0] = func_mode_reg;
						`TZC_IDX_IRQ_STAT:  prdata_next[`TZC_IRQ_W-1:0] = ist_reg;
						`TZC_IDX_IRQ_EN:    prdata_next[`TZC_IRQ_W-1:0] = ien_reg;
						default:            prdata_next = 32'h0000_0000;
					endcase
					if (!addr_ok)
					begin
						prdata_next = 32'h0000_0000;
					end
				end
			end
			tzc_pkg::BUS_ANSWER: bus_next = tzc_pkg::BUS_IDLE;
			default: bus_next = tzc_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			bus_reg     <= tzc_pkg::BUS_IDLE;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			bus_reg     <= bus_next;
			prdata_reg  <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign pready  = (bus_reg == tzc_pkg::BUS_ANSWER);
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	// Configuration registers; the reserved high bits of clock control are kept at zero.
	always_comb
	begin
		clk_ctrl_next  = clk_ctrl_reg;
		io_ctrl_next   = io_ctrl_reg;
		run_ctrl_next  = run_ctrl_reg;
		sync_mode_next = sync_mode_reg;
		func_mode_next = func_mode_reg;
		ien_next       = ien_reg;
		if (wr_en)
		begin
			case (idx)
				`TZC_IDX_CLK_CTRL:  clk_ctrl_next = {3'h0, pwdata[4:0]};
				`TZC_IDX_IO_CTRL:   io_ctrl_next = pwdata[7:0];
				`TZC_IDX_RUN_CTRL:  run_ctrl_next = pwdata[7:0];
				`TZC_IDX_SYNC_MODE: sync_mode_next = pwdata[7:0];
				`TZC_IDX_FUNC_MODE: func_mode_next = pwdata[7:0];
				`TZC_IDX_IRQ_EN:    ien_next = pwdata[`TZC_IRQ_W-1:0];
				default:            ien_next = ien_reg;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			clk_ctrl_reg  <= `TZC_REG8_RST;
			io_ctrl_reg   <= `TZC_REG8_RST;
			run_ctrl_reg  <= `TZC_REG8_RST;
			sync_mode_reg <= `TZC_REG8_RST;
			func_mode_reg <= `TZC_REG8_RST;
			ien_reg       <= '0;
		end
		else
		begin
			clk_ctrl_reg  <= clk_ctrl_next;
			io_ctrl_reg   <= io_ctrl_next;
			run_ctrl_reg  <= run_ctrl_next;
			sync_mode_reg <= sync_mode_next;
			func_mode_reg <= func_mode_next;
			ien_reg       <= ien_next;
		end
	end

	// The prescaler free-runs on every system clock cycle.
	assign system_prescaler_next = system_prescaler_reg + 13'h0001;

	// Pick the counter clock level: a prescaler tap or the synchronised external pin.
	always_comb
	begin
		case (clk_ctrl_reg.psc_sel)
			3'h0:    clk_lvl = 1'b0;
			3'h1:    clk_lvl = system_prescaler_reg[0];
			3'h2:    clk_lvl = system_prescaler_reg[1];
			3'h3:    clk_lvl = system_prescaler_reg[2];
			default: clk_lvl = pins.ext_clk;
		endcase
	end

	assign clk_rise = clk_lvl && !clk_lvl_prev_reg;
	assign clk_fall = !clk_lvl && clk_lvl_prev_reg;

	// Divide-by-one has no tap edge to watch, so it ticks every cycle.
	always_comb
	begin
		if (clk_ctrl_reg.psc_sel == 3'h0)
		begin
			tick = 1'b1;
		end
		else
		begin
			case (clk_ctrl_reg.edge_sel)
				`TZC_EDGE_RISE: tick = clk_rise;
				`TZC_EDGE_FALL: tick = clk_fall;
				default:        tick = clk_rise || clk_fall;
			endcase
		end
	end

	// In sync mode channel one's run bit also starts this counter; any combination
	// mode code still runs the channel as in normal operation.
	assign run = run_ctrl_reg[`TZC_RUN0_BIT] ||
		(sync_mode_reg[`TZC_SYNC_BIT] && run_ctrl_reg[`TZC_RUN1_BIT]);

	// Capture edge select; modes without bit 2 are compare modes and never capture.
	assign cap_rise = pins.cap_pin && !cap_prev_reg;
	assign cap_fall = !pins.cap_pin && cap_prev_reg;
	always_comb
	begin
		if (!io_ctrl_reg[`TZC_IO_CAP_BIT])
		begin
			cap_event = 1'b0;
		end
		else
		begin
			case (io_ctrl_reg[1:0])
				`TZC_EDGE_RISE: cap_event = cap_rise;
				`TZC_EDGE_FALL: cap_event = cap_fall;
				default:        cap_event = cap_rise || cap_fall;
			endcase
		end
	end

	assign ovf_event = run && tick && (counter_reg == 16'hFFFF) &&
		!(wr_en && idx == `TZC_IDX_COUNTER);

	// Counter and capture register; a software write to the counter beats a tick,
	// while a capture edge beats a software write to capture_value.
	always_comb
	begin
		counter_next = counter_reg;
		capture_next = capture_reg;
		if (wr_en && idx == `TZC_IDX_COUNTER)
		begin
			counter_next = pwdata[15:0];
		end
		else if (run && tick)
		begin
			counter_next = counter_reg + 16'h0001;
		end
		if (cap_event)
		begin
			capture_next = counter_reg;
		end
		else if (wr_en && idx == `TZC_IDX_CAPTURE)
		begin
			capture_next = pwdata[15:0];
		end
	end

	// Flag clear needs a prior read of one; a capture in the same cycle still sets it.
	assign flag_clr = wr_en && idx == `TZC_IDX_STATUS && !pwdata[`TZC_FLAG_BIT] && armed_reg;
	always_comb
	begin
		flag_next  = flag_reg;
		armed_next = armed_reg;
		if (rd_done && idx == `TZC_IDX_STATUS && flag_reg)
		begin
			armed_next = 1'b1;
		end
		if (flag_clr)
		begin
			flag_next  = 1'b0;
			armed_next = 1'b0;
		end
		if (cap_event)
		begin
			flag_next = 1'b1;
		end
	end

	// Sticky interrupt status: set wins over a write-one clear in the same cycle.
	always_comb
	begin
		ist_next = ist_reg;
		if (wr_en && idx == `TZC_IDX_IRQ_CLR)
		begin
			ist_next = ist_reg & ~pwdata[`TZC_IRQ_W-1:0];
		end
		if (cap_event)
		begin
			ist_next[`TZC_IRQ_CAP_BIT] = 1'b1;
		end
		if (ovf_event)
		begin
			ist_next[`TZC_IRQ_OVF_BIT] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			system_prescaler_reg <= 13'h0000;
			counter_reg          <= `TZC_REG16_RST;
			capture_reg          <= `TZC_REG16_RST;
			flag_reg             <= 1'b0;
			armed_reg            <= 1'b0;
			ist_reg              <= '0;
			irq_reg              <= 1'b0;
			clk_lvl_prev_reg     <= 1'b0;
			cap_prev_reg         <= 1'b0;
		end
		else
		begin
			system_prescaler_reg <= system_prescaler_next;
			counter_reg          <= counter_next;
			capture_reg          <= capture_next;
			flag_reg             <= flag_next;
			armed_reg            <= armed_next;
			ist_reg              <= ist_next;
			irq_reg              <= |(ist_reg & ien_reg);
			clk_lvl_prev_reg     <= clk_lvl;
			cap_prev_reg         <= pins.cap_pin;
		end
	end

	assign irq = irq_reg;

	// Checks on the channel's behaviour.
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		##1 pready ##1 !pready;
	endsequence

	property p_pre_inc;
		@(posedge sys_clk) disable iff (!rstn)
		1'b1 |=> system_prescaler_reg == $past(system_prescaler_reg) + 13'h0001;
	endproperty
	a_pre_inc: assert property (p_pre_inc) else $error("prescaler missed a step");

	property p_stopped;
		@(posedge sys_clk) disable iff (!rstn)
		(!run && !(wr_en && idx == `TZC_IDX_COUNTER)) |=> $stable(counter_reg);
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped counter moved");

	property p_div8;
		@(posedge sys_clk) disable iff (!rstn)
		(clk_ctrl_reg == 8'h03 && run && !wr_en) ##1 (counter_reg != $past(counter_reg))
			|-> system_prescaler_reg[2:0] == 3'h5;
	endproperty
	a_div8: assert property (p_div8) else $error("divide by eight tick misplaced");

	property p_div8_rate;
		@(posedge sys_clk) disable iff (!rstn)
		(clk_ctrl_reg == 8'h03 && run && system_prescaler_reg[2:0] == 3'h4 && !wr_en)
			|=> counter_reg == $past(counter_reg) + 16'h0001;
	endproperty
	a_div8_rate: assert property (p_div8_rate) else $error("rising tap did not count");

	property p_capture;
		@(posedge sys_clk) disable iff (!rstn)
		cap_event |=> capture_reg == $past(counter_reg) && flag_reg;
	endproperty
	a_capture: assert property (p_capture) else $error("capture value or flag wrong");

	property p_cap_mode;
		@(posedge sys_clk) disable iff (!rstn)
		(io_ctrl_reg[2:0] == 3'h4 && $rose(pins.cap_pin)) |-> cap_event;
	endproperty
	a_cap_mode: assert property (p_cap_mode) else $error("rising capture edge lost");

	property p_flag_fall;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(flag_reg) |-> $past(flag_clr) && !$past(cap_event);
	endproperty
	a_flag_fall: assert property (p_flag_fall) else $error("flag dropped without clear");

	property p_flag_set;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(flag_reg) |-> $past(cap_event);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag set with no capture");

	property p_bus;
		@(posedge sys_clk) disable iff (!rstn)
		s_setup |-> s_answer;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer not one cycle");

endmodule

// ==== tb/tzc_pulse_src.sv ====
// Behavioural pulse source that drives the capture pin and the external clock pin.
`timescale 1ns/1ps
module tzc_pulse_src (
	input  wire logic sys_clk,
	output logic      cap_pin,
	output logic      ext_pin
);
	// Both pins rest low between pulses, as a driven source line would.
	initial
	begin
		cap_pin = 1'b0;
		ext_pin = 1'b0;
	end

	// Sends n rising edges on one pin, each level held len cycles.
	// Short levels would be lost in the two-flop synchroniser, so len stays above two.
	task automatic pulses(input bit on_ext, input int n, input int len);
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk);
			if (on_ext)
				ext_pin <= 1'b1;
			else
				cap_pin <= 1'b1;
			repeat (len) @(posedge sys_clk);
			ext_pin <= 1'b0;
			cap_pin <= 1'b0;
			repeat (len - 1) @(posedge sys_clk);
		end
	endtask
endmodule

// ==== tb/tzc_capture_top_tb.sv ====
// Self-checking testbench for the capture channel with its APB register slave.
`timescale 1ns/1ps
`include "tzc_consts.svh"
module tzc_capture_top_tb;
	logic        sys_clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap_pin;
	logic        ext_pin;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	logic [31:0] held;
	int          n_errors;
	int          n_compared;

	// Registers expected to read zero straight after reset.
	localparam logic [15:0] RST_TAB [9] = '{`TZC_IDX_CLK_CTRL, `TZC_IDX_IO_CTRL,
		`TZC_IDX_STATUS, `TZC_IDX_COUNTER, `TZC_IDX_CAPTURE, `TZC_IDX_RUN_CTRL,
		`TZC_IDX_SYNC_MODE, `TZC_IDX_FUNC_MODE, `TZC_IDX_IRQ_EN};

	tzc_capture_top uut (
		.sys_clk           (sys_clk),
		.rstn              (rstn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.capture_input_pin (cap_pin),
		.ext_clock_pin     (ext_pin),
		.irq               (irq)
	);

	tzc_pulse_src src (
		.sys_clk (sys_clk),
		.cap_pin (cap_pin),
		.ext_pin (ext_pin)
	);

	// Clock of 50 ns period.
	always #25 sys_clk = ~sys_clk;

	// One APB transfer; pready and the answer are taken at the rising edge that ends it.
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		input logic [13:0] hi);
		int t;
		t = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {hi, idx, 2'h0};
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rd = prdata;
		err = pslverr;
		if (t >= 20)
			n_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 14'h0);
	endtask

	task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0, 14'h0);
		check(rd, exp);
	endtask

	// A count is accepted inside a window because the prescaler phase is free-running.
	task automatic rrange(input logic [15:0] idx, input int lo, input int hi);
		apb(1'b0, idx, 32'h0, 14'h0);
		n_compared++;
		if ($isunknown(rd) || rd < lo || rd > hi)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, rd, lo);
		end
	endtask

	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		check({31'h0, irq}, {31'h0, exp});
	endtask

	task automatic test_done;
		$display("Counts: compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog; the tests need well under a thousand cycles.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		test_done();
	end

	// Main sequence of tests.
	initial
	begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		n_errors = 0;
		n_compared = 0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rchk(RST_TAB[i], 32'h0);
		rchk(`TZC_IDX_IRQ_CLR, 32'h0);
		$display("Test reset values ended");

		wr(`TZC_IDX_CLK_CTRL, 32'hFF);
		rchk(`TZC_IDX_CLK_CTRL, 32'h1F);
		wr(`TZC_IDX_COUNTER, 32'h1A5A5);
		rchk(`TZC_IDX_COUNTER, 32'hA5A5);
		wr(`TZC_IDX_CAPTURE, 32'h1234);
		rchk(`TZC_IDX_CAPTURE, 32'h1234);
		wr(`TZC_IDX_SYNC_MODE, 32'h01);
		rchk(`TZC_IDX_SYNC_MODE, 32'h01);
		wr(`TZC_IDX_FUNC_MODE, 32'h03);
		rchk(`TZC_IDX_FUNC_MODE, 32'h03);
		wr(`TZC_IDX_FUNC_MODE, 32'h00);
		wr(`TZC_IDX_SYNC_MODE, 32'h00);
		apb(1'b0, 16'hF702, 32'h0, 14'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, `TZC_IDX_CLK_CTRL, 32'h03, 14'h1);
		check({31'h0, err}, 32'h1);
		rchk(`TZC_IDX_CLK_CTRL, 32'h1F);
		$display("Test register access ended");

		// Divide by eight over about 84 cycles gives ten or eleven ticks.
		wr(`TZC_IDX_COUNTER, 32'h0);
		wr(`TZC_IDX_CLK_CTRL, 32'h03);
		wr(`TZC_IDX_RUN_CTRL, 32'h01);
		repeat (80) @(posedge sys_clk);
		wr(`TZC_IDX_RUN_CTRL, 32'h00);
		rrange(`TZC_IDX_COUNTER, 9, 12);
		held = rd;
		repeat (40) @(posedge sys_clk);
		rchk(`TZC_IDX_COUNTER, held);
		$display("Test prescaled count ended");

		wr(`TZC_IDX_COUNTER, 32'h0);
		wr(`TZC_IDX_CLK_CTRL, 32'h04);
		wr(`TZC_IDX_RUN_CTRL, 32'h01);
		src.pulses(1'b1, 5, 3);
		repeat (8) @(posedge sys_clk);
		wr(`TZC_IDX_RUN_CTRL, 32'h00);
		rchk(`TZC_IDX_COUNTER, 32'h5);
		$display("Test external clock ended");

		wr(`TZC_IDX_COUNTER, 32'h0);
		wr(`TZC_IDX_CLK_CTRL, 32'h00);
		wr(`TZC_IDX_RUN_CTRL, 32'h02);
		repeat (20) @(posedge sys_clk);
		rchk(`TZC_IDX_COUNTER, 32'h0);
		wr(`TZC_IDX_SYNC_MODE, 32'h01);
		repeat (20) @(posedge sys_clk);
		wr(`TZC_IDX_RUN_CTRL, 32'h00);
		rrange(`TZC_IDX_COUNTER, 20, 40);
		wr(`TZC_IDX_SYNC_MODE, 32'h00);
		$display("Test sync mode ended");

		// Every-cycle ticks for 23 edges carry the counter through FFFF to 0007.
		wr(`TZC_IDX_COUNTER, 32'hFFF0);
		wr(`TZC_IDX_RUN_CTRL, 32'h01);
		repeat (20) @(posedge sys_clk);
		wr(`TZC_IDX_RUN_CTRL, 32'h00);
		rchk(`TZC_IDX_COUNTER, 32'h7);
		rchk(`TZC_IDX_IRQ_STAT, 32'h2);
		wr(`TZC_IDX_IRQ_CLR, 32'h02);
		rchk(`TZC_IDX_IRQ_STAT, 32'h0);
		$display("Test counter overflow ended");

		// Counter is stopped, so the captured value is exact.
		wr(`TZC_IDX_COUNTER, 32'h0ABC);
		wr(`TZC_IDX_IO_CTRL, 32'h04);
		rchk(`TZC_IDX_STATUS, 32'h0);
		wr(`TZC_IDX_IRQ_EN, 32'h01);
		src.pulses(1'b0, 1, 4);
		repeat (6) @(posedge sys_clk);
		rchk(`TZC_IDX_CAPTURE, 32'h0ABC);
		irq_chk(1'b1);
		wr(`TZC_IDX_STATUS, 32'h0);
		rchk(`TZC_IDX_STATUS, 32'h1);
		wr(`TZC_IDX_STATUS, 32'h0);
		rchk(`TZC_IDX_STATUS, 32'h0);
		rchk(`TZC_IDX_IRQ_STAT, 32'h1);
		wr(`TZC_IDX_IRQ_EN, 32'h00);
		irq_chk(1'b0);
		wr(`TZC_IDX_IRQ_EN, 32'h01);
		irq_chk(1'b1);
		wr(`TZC_IDX_IRQ_CLR, 32'h01);
		irq_chk(1'b0);
		rchk(`TZC_IDX_IRQ_STAT, 32'h0);
		$display("Test capture and interrupt ended");

		wr(`TZC_IDX_IO_CTRL, 32'h00);
		wr(`TZC_IDX_COUNTER, 32'h0555);
		src.pulses(1'b0, 1, 4);
		repeat (6) @(posedge sys_clk);
		rchk(`TZC_IDX_CAPTURE, 32'h0ABC);
		rchk(`TZC_IDX_STATUS, 32'h0);
		$display("Test capture disabled ended");

		// Falling-edge capture mode takes the stopped counter when the pin drops.
		wr(`TZC_IDX_IO_CTRL, 32'h05);
		src.pulses(1'b0, 1, 4);
		repeat (6) @(posedge sys_clk);
		rchk(`TZC_IDX_CAPTURE, 32'h0555);
		rchk(`TZC_IDX_STATUS, 32'h1);
		$display("Test falling capture ended");
		test_done();
	end
endmodule
